// File: hw/dcff_defs.vh
// Overview of operation
// - A clear empties the buffer, zeroes both pointers and drives empty flag low.
// - After clear rises, data outputs are low if output enable is low, else off.
// - Free-running write and read clocks during clear leave the cleared state intact.
// - Full flag may rise one write edge late when a read edge came just before.
// - Empty flag may rise one read edge late when a write edge came just before.
// - Synchronous almost-empty changes on a read edge, or the next one under skew.
// - Synchronous almost-full changes on a write edge, or the next one under skew.
// - First word reaches the read port the read cycle after empty flag rises.
// - Read on the edge asserting almost-empty leaves n-1 words at assertion.
// - Write on the edge asserting almost-full leaves full minus m-1 words.
// - Flags may move during replay and are all valid after the recovery interval.
// - Storage is a dual-port 16K by 18 array with separate read and write pointers.
// - Empty flag low exactly when no words; changes on read edges and on clear only; blocks reads.
// - Full flag low exactly at full depth; changes on write edges and on clear only; blocks writes.
// - Almost-empty at count up to n, almost-full from depth minus m, half above half.
// - Select low: almost flags follow their clocks; select high: updated every cycle.
`ifndef DCFF_DEFS_VH
`define DCFF_DEFS_VH

`define DCFF_DATA_W      18
`define DCFF_ADDR_W      14
`define DCFF_PTR_W       15
`define DCFF_OFS_W       14
`define DCFF_DEPTH       15'h4000
`define DCFF_HALF        15'h2000
`define DCFF_OFS_DEF     14'h007F

`define DCFF_PIN_W       26
`define DCFF_PIN_RST     26'h0E80000

`define DCFF_REG_EOFS    12'h000
`define DCFF_REG_FOFS    12'h004
`define DCFF_REG_STAT    12'h008

`define DCFF_ST_EMPTY_N  0
`define DCFF_ST_AE_N     1
`define DCFF_ST_HF_N     2
`define DCFF_ST_AF_N     3
`define DCFF_ST_FULL_N   4
`define DCFF_ST_CLEAR    5
`define DCFF_ST_CNT_LSB  16

`endif

// File: hw/dcff_sync.v
`timescale 1ns/1ps
`default_nettype none
module dcff_sync #(
  parameter W   = 1,
  parameter RST = 1'b0
) (
  input  wire         core_clk,
  input  wire         srst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer i;

  // A change is taken only when the last two stages agree
  always @(posedge core_clk) begin
    if (srst) begin
      s1   <= RST;
      s2   <= RST;
      s3   <= RST;
      dout <= RST;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      for (i = 0; i < W; i = i + 1) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end
endmodule // dcff_sync
`default_nettype wire

// File: hw/dcff_mem.v
`timescale 1ns/1ps
`default_nettype none
module dcff_mem #(
  parameter DW = 18,
  parameter AW = 14
) (
  input  wire          core_clk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire          re,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] store [0:(1<<AW)-1];

  always @(posedge core_clk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
    if (re) begin
      rdata <= store[raddr];
    end
  end
endmodule // dcff_mem
`default_nettype wire

// File: hw/dcff_core.v
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dcff_defs.vh"
module dcff_core (
  input  wire                      core_clk,
  input  wire                      srst,
  // Pins from the writer and reader, foreign to core_clk
  input  wire                      write_clk_pin,
  input  wire                      read_clk_pin,
  input  wire                      write_enable_n,
  input  wire                      read_enable_n,
  input  wire [`DCFF_DATA_W-1:0]   write_data,
  input  wire                      output_enable_n,
  input  wire                      buffer_clear_n,
  input  wire                      sync_almost_flag_select_n,
  input  wire                      replay_strobe,
  // Read port and flags
  output reg  [`DCFF_DATA_W-1:0]   read_data,
  output reg                       read_data_oe_n,
  output reg                       empty_flag_n,
  output reg                       full_flag_n,
  output reg                       almost_empty_flag_n,
  output reg                       almost_full_flag_n,
  output reg                       half_full_flag_n,
  // AHB-Lite slave
  input  wire                      hsel,
  input  wire [31:0]               haddr,
  input  wire [1:0]                htrans,
  input  wire                      hwrite,
  input  wire [2:0]                hsize,
  input  wire [31:0]               hwdata,
  input  wire                      hready,
  output reg                       hreadyout,
  output reg                       hresp,
  output reg  [31:0]               hrdata
);
  wire [`DCFF_PIN_W-1:0]   pins_raw;
  wire [`DCFF_PIN_W-1:0]   pins;
  wire                     wclk_s;
  wire                     rclk_s;
  wire                     wen_n_s;
  wire                     ren_n_s;
  wire [`DCFF_DATA_W-1:0]  wdata_s;
  wire                     oe_n_s;
  wire                     clear_n_s;
  wire                     sel_n_s;
  wire                     replay_s;
  wire [`DCFF_DATA_W-1:0]  mem_rdata;

  reg                      wclk_q;
  reg                      rclk_q;
  reg                      replay_q;
  reg  [`DCFF_PTR_W-1:0]   wr_ptr;
  reg  [`DCFF_PTR_W-1:0]   rd_ptr;
  reg  [`DCFF_PTR_W-1:0]   rd_ptr_w;
  reg  [`DCFF_PTR_W-1:0]   wr_ptr_r;
  reg                      rd_pend;
  reg  [`DCFF_OFS_W-1:0]   empty_offset;
  reg  [`DCFF_OFS_W-1:0]   full_offset;
  reg                      wr_pend;
  reg  [11:0]              wr_addr;

  wire                     w_edge;
  wire                     r_edge;
  wire                     replay_rise;
  wire                     clearing;
  wire                     wr_ok;
  wire                     rd_ok;
  wire [`DCFF_PTR_W-1:0]   next_wr_ptr;
  wire [`DCFF_PTR_W-1:0]   next_rd_ptr;
  wire [`DCFF_PTR_W-1:0]   wcount;
  wire [`DCFF_PTR_W-1:0]   rcount;
  wire [`DCFF_PTR_W-1:0]   ae_count;
  wire [`DCFF_PTR_W-1:0]   af_count;
  wire [`DCFF_PTR_W-1:0]   count;
  wire [`DCFF_PTR_W-1:0]   ae_limit;
  wire [`DCFF_PTR_W-1:0]   af_limit;
  wire                     bus_take;
  reg  [31:0]              next_hrdata;

  assign pins_raw = {write_clk_pin, read_clk_pin, write_enable_n, read_enable_n,
                     output_enable_n, buffer_clear_n, sync_almost_flag_select_n,
                     replay_strobe, write_data};

  dcff_sync #(
    .W   (`DCFF_PIN_W),
    .RST (`DCFF_PIN_RST)
  ) u_pin_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .din      (pins_raw),
    .dout     (pins)
  );

  assign wclk_s    = pins[25];
  assign rclk_s    = pins[24];
  assign wen_n_s   = pins[23];
  assign ren_n_s   = pins[22];
  assign oe_n_s    = pins[21];
  assign clear_n_s = pins[20];
  assign sel_n_s   = pins[19];
  assign replay_s  = pins[18];
  assign wdata_s   = pins[`DCFF_DATA_W-1:0];

  always @(posedge core_clk) begin
    if (srst) begin
      wclk_q   <= 1'b0;
      rclk_q   <= 1'b0;
      replay_q <= 1'b0;
    end else begin
      wclk_q   <= wclk_s;
      rclk_q   <= rclk_s;
      replay_q <= replay_s;
    end
  end

  assign w_edge      = wclk_s & ~wclk_q;
  assign r_edge      = rclk_s & ~rclk_q;
  assign replay_rise = replay_s & ~replay_q;
  assign clearing    = ~clear_n_s;

  assign wr_ok = w_edge & ~wen_n_s & full_flag_n & ~clearing;
  assign rd_ok = r_edge & ~ren_n_s & empty_flag_n & ~clearing;

  assign next_wr_ptr = wr_ptr + {{(`DCFF_PTR_W-1){1'b0}}, wr_ok};
  assign next_rd_ptr = rd_ptr + {{(`DCFF_PTR_W-1){1'b0}}, rd_ok};

  assign wcount = next_wr_ptr - rd_ptr_w;
  assign rcount = wr_ptr_r - next_rd_ptr;
  assign count  = wr_ptr - rd_ptr;
  assign ae_count = wr_ptr_r - rd_ptr;
  assign af_count = wr_ptr - rd_ptr_w;

  assign ae_limit = {1'b0, empty_offset};
  assign af_limit = `DCFF_DEPTH - {1'b0, full_offset};

  dcff_mem #(
    .DW (`DCFF_DATA_W),
    .AW (`DCFF_ADDR_W)
  ) u_mem (
    .core_clk (core_clk),
    .we       (wr_ok),
    .waddr    (wr_ptr[`DCFF_ADDR_W-1:0]),
    .wdata    (wdata_s),
    .re       (rd_ok),
    .raddr    (rd_ptr[`DCFF_ADDR_W-1:0]),
    .rdata    (mem_rdata)
  );

  // Pointers
  always @(posedge core_clk) begin
    if (srst) begin
      wr_ptr   <= {`DCFF_PTR_W{1'b0}};
      rd_ptr   <= {`DCFF_PTR_W{1'b0}};
      rd_ptr_w <= {`DCFF_PTR_W{1'b0}};
      wr_ptr_r <= {`DCFF_PTR_W{1'b0}};
    end else if (clearing) begin
      wr_ptr   <= {`DCFF_PTR_W{1'b0}};
      rd_ptr   <= {`DCFF_PTR_W{1'b0}};
      rd_ptr_w <= {`DCFF_PTR_W{1'b0}};
      wr_ptr_r <= {`DCFF_PTR_W{1'b0}};
    end else begin
      wr_ptr <= next_wr_ptr;
      if (replay_rise) begin
        rd_ptr <= {`DCFF_PTR_W{1'b0}};
      end else begin
        rd_ptr <= next_rd_ptr;
      end
      rd_ptr_w <= rd_ptr;
      wr_ptr_r <= wr_ptr;
    end
  end

  // Flags
  always @(posedge core_clk) begin
    if (srst || clearing) begin
      empty_flag_n        <= 1'b0;
      full_flag_n         <= 1'b1;
      almost_empty_flag_n <= 1'b0;
      almost_full_flag_n  <= 1'b1;
      half_full_flag_n    <= 1'b1;
    end else begin
      if (r_edge) begin
        empty_flag_n <= (rcount != {`DCFF_PTR_W{1'b0}});
      end
      if (w_edge) begin
        full_flag_n <= (wcount != `DCFF_DEPTH);
      end
      if (!sel_n_s) begin
        if (r_edge) begin
          almost_empty_flag_n <= (ae_count > ae_limit);
        end
        if (w_edge) begin
          almost_full_flag_n <= (af_count < af_limit);
        end
      end else begin
        almost_empty_flag_n <= (count > ae_limit);
        almost_full_flag_n  <= (count < af_limit);
      end
      half_full_flag_n <= (count <= `DCFF_HALF);
    end
  end

  // Read port
  always @(posedge core_clk) begin
    if (srst || clearing) begin
      rd_pend        <= 1'b0;
      read_data      <= {`DCFF_DATA_W{1'b0}};
      read_data_oe_n <= 1'b1;
    end else begin
      rd_pend <= rd_ok;
      if (rd_pend) begin
        read_data <= mem_rdata;
      end
      read_data_oe_n <= oe_n_s;
    end
  end

  // Bus slave
  assign bus_take = hsel & htrans[1] & hready;

  always @* begin
    next_hrdata = 32'h00000000;
    case (haddr[11:0])
      `DCFF_REG_EOFS: begin
        next_hrdata[`DCFF_OFS_W-1:0] = empty_offset;
      end
      `DCFF_REG_FOFS: begin
        next_hrdata[`DCFF_OFS_W-1:0] = full_offset;
      end
      `DCFF_REG_STAT: begin
        next_hrdata[`DCFF_ST_EMPTY_N] = empty_flag_n;
        next_hrdata[`DCFF_ST_AE_N]    = almost_empty_flag_n;
        next_hrdata[`DCFF_ST_HF_N]    = half_full_flag_n;
        next_hrdata[`DCFF_ST_AF_N]    = almost_full_flag_n;
        next_hrdata[`DCFF_ST_FULL_N]  = full_flag_n;
        next_hrdata[`DCFF_ST_CLEAR]   = clearing;
        next_hrdata[`DCFF_ST_CNT_LSB+`DCFF_PTR_W-1:`DCFF_ST_CNT_LSB] = count;
      end
      default: begin
        next_hrdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (srst) begin
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      hrdata       <= 32'h00000000;
      wr_pend      <= 1'b0;
      wr_addr      <= 12'h000;
      empty_offset <= `DCFF_OFS_DEF;
      full_offset  <= `DCFF_OFS_DEF;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= bus_take & hwrite;
      if (bus_take) begin
        wr_addr <= haddr[11:0];
      end
      if (bus_take && !hwrite) begin
        hrdata <= next_hrdata;
      end
      if (wr_pend) begin
        if (wr_addr == `DCFF_REG_EOFS) begin
          empty_offset <= hwdata[`DCFF_OFS_W-1:0];
        end
        if (wr_addr == `DCFF_REG_FOFS) begin
          full_offset <= hwdata[`DCFF_OFS_W-1:0];
        end
      end
    end
  end
endmodule // dcff_core
`default_nettype wire

// File: tb/dcff_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcff_defs.vh"
module dcff_props (
  input wire logic                    core_clk,
  input wire logic                    srst,
  input wire logic                    read_clk_pin,
  input wire logic                    write_clk_pin,
  input wire logic                    buffer_clear_n,
  input wire logic                    output_enable_n,
  input wire logic                    sync_almost_flag_select_n,
  input wire logic [`DCFF_DATA_W-1:0] read_data,
  input wire logic                    read_data_oe_n,
  input wire logic                    empty_flag_n,
  input wire logic                    full_flag_n,
  input wire logic                    almost_empty_flag_n,
  input wire logic                    almost_full_flag_n,
  input wire logic                    half_full_flag_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [3:0] rc;
  logic [3:0] wc;
  logic       rp;
  logic       wp;
  // Cycles since the last rising edge seen on each far-side clock pin
  always_ff @(posedge core_clk) begin
    rp <= read_clk_pin;
    wp <= write_clk_pin;
    if (srst || (read_clk_pin && !rp)) rc <= 4'h0;
    else if (rc != 4'hF) rc <= rc + 4'h1;
    if (srst || (write_clk_pin && !wp)) wc <= 4'h0;
    else if (wc != 4'hF) wc <= wc + 4'h1;
  end
  sequence s_cleared;
    !buffer_clear_n [*8];
  endsequence
  sequence s_open;
    (buffer_clear_n && $stable(output_enable_n)) [*8];
  endsequence
  a_clear_flags: assert property (s_cleared |-> !empty_flag_n && full_flag_n &&
    !almost_empty_flag_n && almost_full_flag_n && half_full_flag_n) else $error("flags not cleared");
  a_clear_quiet: assert property (s_cleared |-> read_data_oe_n && read_data == '0)
    else $error("outputs active in clear");
  a_oe_follow: assert property (s_open |-> read_data_oe_n == output_enable_n)
    else $error("output enable not followed");
  a_empty_edge: assert property ($changed(empty_flag_n) && buffer_clear_n
    && $past(buffer_clear_n, 8) |-> rc < 4'hA) else $error("empty moved off read edge");
  a_full_edge: assert property ($changed(full_flag_n) && buffer_clear_n
    && $past(buffer_clear_n, 8) |-> wc < 4'hA) else $error("full moved off write edge");
  a_ae_sync: assert property ($changed(almost_empty_flag_n) && !sync_almost_flag_select_n
    && buffer_clear_n && $past(!sync_almost_flag_select_n && buffer_clear_n, 8) |-> rc < 4'hA)
    else $error("almost empty off read edge");
  a_af_sync: assert property ($changed(almost_full_flag_n) && !sync_almost_flag_select_n
    && buffer_clear_n && $past(!sync_almost_flag_select_n && buffer_clear_n, 8) |-> wc < 4'hA)
    else $error("almost full off write edge");
  a_data_read: assert property ($changed(read_data) && buffer_clear_n
    && $past(buffer_clear_n, 8) |-> rc < 4'hA) else $error("data moved off read edge");
endmodule // dcff_props
bind dcff_core dcff_props i_props (.*);
`default_nettype wire

// File: tb/dcff_far.sv
`timescale 1ns/1ps
`default_nettype none
module dcff_far (
  input  wire logic        core_clk,
  output var  logic        write_clk_pin,
  output var  logic        read_clk_pin,
  output var  logic        write_enable_n,
  output var  logic        read_enable_n,
  output var  logic [17:0] write_data,
  output var  logic        buffer_clear_n,
  output var  logic        replay_strobe
);
  initial begin
    write_clk_pin = 1'b0;
    read_clk_pin = 1'b0;
    write_enable_n = 1'b1;
    read_enable_n = 1'b1;
    write_data = 18'h0;
    buffer_clear_n = 1'b0;
    replay_strobe = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Clocks stand still outside a pulse or a burst; every level is held 4 cycles
  task automatic pulse(input logic [1:0] clk, input logic [1:0] en, input logic [17:0] d);
    @(posedge core_clk);
    write_enable_n <= ~en[1];
    read_enable_n <= ~en[0];
    write_data <= d;
    hold(4);
    write_clk_pin <= clk[1];
    read_clk_pin <= clk[0];
    hold(4);
    write_clk_pin <= 1'b0;
    read_clk_pin <= 1'b0;
    hold(4);
    write_enable_n <= 1'b1;
    read_enable_n <= 1'b1;
    write_data <= ~d;
  endtask
  task automatic clear();
    @(posedge core_clk);
    buffer_clear_n <= 1'b0;
    pulse(2'b11, 2'b00, 18'h0);
    buffer_clear_n <= 1'b1;
    hold(8);
  endtask
  task automatic replay();
    @(posedge core_clk);
    replay_strobe <= 1'b1;
    hold(4);
    replay_strobe <= 1'b0;
    hold(8);
    pulse(2'b11, 2'b00, 18'h0);
  endtask
  // Back-to-back writes on a steady 8-cycle write clock
  task automatic burst(input int n, input logic [17:0] d);
    @(posedge core_clk);
    write_enable_n <= 1'b0;
    write_data <= d;
    repeat (n) begin
      hold(4);
      write_clk_pin <= 1'b1;
      hold(4);
      write_clk_pin <= 1'b0;
      write_data <= write_data + 18'h1;
    end
    hold(4);
    write_enable_n <= 1'b1;
  endtask
endmodule // dcff_far
`default_nettype wire

// File: tb/dual_clock_fifo_flag_reset_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin #1; cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module dual_clock_fifo_flag_reset_core_tb;
  logic        core_clk, srst, wclk, rclk, wen_n, ren_n, oe_n, clr_n, sel_n, rep;
  logic [17:0] wd, read_data;
  logic        hsel, hwrite, hready, hreadyout, hresp, oe_q, ef, ff, aef, aff, hff;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          err_count, cmp_count, i;
  wire  [17:0] q_bus = oe_q ? 18'hz : read_data;
  assign hready = hreadyout;
  always #50 core_clk = ~core_clk;
  dcff_far i_far (.core_clk(core_clk), .write_clk_pin(wclk), .read_clk_pin(rclk),
    .write_enable_n(wen_n), .read_enable_n(ren_n), .write_data(wd),
    .buffer_clear_n(clr_n), .replay_strobe(rep));
  dcff_core i_dut (.core_clk(core_clk), .srst(srst), .write_clk_pin(wclk),
    .read_clk_pin(rclk), .write_enable_n(wen_n), .read_enable_n(ren_n), .write_data(wd),
    .output_enable_n(oe_n), .buffer_clear_n(clr_n), .sync_almost_flag_select_n(sel_n),
    .replay_strobe(rep), .read_data(read_data), .read_data_oe_n(oe_q), .empty_flag_n(ef),
    .full_flag_n(ff), .almost_empty_flag_n(aef), .almost_full_flag_n(aff),
    .half_full_flag_n(hff), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));
  task automatic give_verdict();
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= w;
    do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin err_count++; give_verdict(); end
  endtask
  initial begin
    core_clk = 0; srst = 1; hsel = 1; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
    hwdata = 0; oe_n = 1; sel_n = 0; err_count = 0; cmp_count = 0;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    i_far.clear();
    `CHK("empty", 1'b0, ef)
    `CHK("aempty", 1'b0, aef)
    `CHK("q", 18'hz, q_bus)
    @(posedge core_clk);
    oe_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    `CHK("q", 18'h0, q_bus)
    ahb(1'b0, 12'h000, 0);
    `CHK("eofs", 32'h7F, rd)
    ahb(1'b1, 12'h000, 3);
    ahb(1'b1, 12'h004, 16380);
    ahb(1'b0, 12'h004, 0);
    `CHK("fofs", 32'h3FFC, rd)
    ahb(1'b0, 12'h00C, 0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("hresp", 1'b0, hresp)
    `CHK("hready", 1'b1, hreadyout)
    for (i = 0; i < 6; i++) begin
      i_far.pulse(2'b10, 2'b10, 18'h1000 + i);
      `CHK("afull", i < 4, aff)
      `CHK("full", 1'b1, ff)
    end
    `CHK("empty", 1'b0, ef)
    `CHK("afull", 1'b0, aff)
    ahb(1'b0, 12'h008, 0);
    `CHK("status", 32'h00060014, rd)
    i_far.pulse(2'b01, 2'b00, 0);
    `CHK("empty", 1'b1, ef)
    `CHK("aempty", 1'b1, aef)
    for (i = 0; i < 6; i++) begin
      i_far.pulse(2'b01, 2'b01, 0);
      `CHK("q", 18'h1000 + i, q_bus)
      `CHK("aempty", (6 - i) > 3, aef)
    end
    `CHK("empty", 1'b0, ef)
    i_far.pulse(2'b01, 2'b01, 0);
    `CHK("q", 18'h1005, q_bus)
    @(posedge core_clk);
    sel_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    `CHK("afull", 1'b1, aff)
    i_far.replay();
    i_far.pulse(2'b01, 2'b00, 0);
    `CHK("empty", 1'b1, ef)
    i_far.pulse(2'b01, 2'b01, 0);
    `CHK("q", 18'h1000, q_bus)
    `CHK("aempty", 1'b1, aef)
    i_far.burst(8187, 18'h2000);
    `CHK("half", 1'b1, hff)
    i_far.burst(1, 18'h0);
    `CHK("half", 1'b0, hff)
    `CHK("full", 1'b1, ff)
    ahb(1'b0, 12'h008, 0);
    `CHK("status", 32'h20010013, rd)
    i_far.clear();
    `CHK("empty", 1'b0, ef)
    `CHK("q", 18'h0, q_bus)
    give_verdict();
  end
endmodule // dual_clock_fifo_flag_reset_core_tb
`default_nettype wire
